// file: rtl/btc_classify.sv
// Pure combinational instruction classifier
`timescale 1ns/1ps
module btc_classify (
  input  wire logic [13:0]     instr,
  output btc_pkg::btc_op_t     op
);
  import btc_pkg::*;

  // Exact encodings first, then the field patterns
  always_comb begin
    op = BTC_OTHER;
    if (instr == OP_ZERO_ACC) begin                         // RULE8
      op = BTC_ZERO_ACC;
    end else if (instr == OP_KICK_WD) begin                 // RULE9
      op = BTC_KICK_WD;
    end else if (instr[13:9] == TOP_SKIP_LO) begin          // RULE1
      op = BTC_SKIP_LO;
    end else if (instr[13:9] == TOP_SKIP_HI) begin          // RULE2
      op = BTC_SKIP_HI;
    end else if (instr[13:12] == TOP_CALL) begin            // RULE10
      op = BTC_CALL;
    end else if (instr[13:7] == TOP_ZERO_DR) begin          // RULE7
      op = BTC_ZERO_DR;
    end
  end
endmodule // btc_classify

// file: rtl/btc_decode.sv
// Decode/execute for bit-test skips, call and the clear instructions
`timescale 1ns/1ps
module btc_decode (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  input  wire logic [11:0] pc_now,
  input  wire logic [7:0]  rd_data,
  output logic [6:0]       rd_addr,
  output logic             busy,
  output logic             flush_next,
  output logic             stack_push,
  output logic [11:0]      stack_data,
  output logic             pc_load,
  output logic [11:0]      pc_target,
  output logic             reg_wr,
  output logic [6:0]       reg_wr_addr,
  output logic [7:0]       reg_wr_data,
  output logic             acc_wr,
  output logic [7:0]       acc_wr_data,
  output logic             zero_flag_set,
  output logic             wd_clear,
  output logic             expiry_flag_wr,
  output logic             expiry_flag,
  output logic             sleep_flag_wr,
  output logic             sleep_flag
);
  import btc_pkg::*;

  // Two-cycle instructions spend their second cycle in BTC_SECOND
  typedef enum {BTC_IDLE, BTC_SECOND} btc_state_t;

  // Sequencer state
  btc_state_t  state_q;
  btc_state_t  state_d;
  logic        busy_d;

  // Decoded view of the word on instr
  btc_op_t     op;
  logic        take;
  logic [2:0]  bit_idx;
  logic        bit_val;
  logic        skip_hit;

  // Next values of the skip and call outputs
  logic        flush_d;
  logic        push_d;
  logic [11:0] sdata_d;
  logic        pcl_d;
  logic [11:0] ptgt_d;

  // Next values of the clear outputs
  logic        rw_d;
  logic [6:0]  rwa_d;
  logic [7:0]  rwd_d;
  logic [6:0]  rda_d;
  logic        aw_d;
  logic [7:0]  awd_d;
  logic        zs_d;

  // Next values of the watchdog outputs
  logic        wd_d;
  logic        exp_d;
  logic        slp_d;

  // A bit test skips when the tested bit matches the polarity of its opcode
  function automatic logic skip_wanted(input btc_op_t kind, input logic tested);
    logic lo_hit;
    logic hi_hit;
    lo_hit      = (kind == BTC_SKIP_LO) && !tested;          // RULE1
    hi_hit      = (kind == BTC_SKIP_HI) && tested;           // RULE2
    skip_wanted = lo_hit || hi_hit;
  endfunction

  btc_classify u_classify (
    .instr (instr),
    .op    (op)
  );

  // Operand fields: 3-bit index, 6-bit address for bit tests
  assign bit_idx  = instr[BIT_LSB +: 3];                     // RULE3
  assign bit_val  = rd_data[bit_idx];
  assign skip_hit = skip_wanted(op, bit_val);
  // The second cycle of a skip or call swallows whatever arrives then
  assign take     = instr_valid && (state_q == BTC_IDLE);

  // Sequencer next state; bit tests and calls leave every status flag alone
  always_comb begin
    state_d = BTC_IDLE;
    busy_d  = 1'b0;
    if (take) begin
      unique case (op)
        BTC_SKIP_LO,
        BTC_SKIP_HI: begin
          if (skip_hit) begin                                // RULE1
            state_d = BTC_SECOND;
            busy_d  = 1'b1;
          end
        end
        BTC_CALL: begin
          state_d = BTC_SECOND;                              // RULE6
          busy_d  = 1'b1;                                    // RULE6
        end
        BTC_ZERO_DR,
        BTC_ZERO_ACC,
        BTC_KICK_WD,
        BTC_OTHER: begin
          state_d = BTC_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BTC_IDLE;
      busy    <= 1'b0;
    end else begin
      state_q <= state_d;
      busy    <= busy_d;
    end
  end

  // Skip strobe: the fetch path turns the next word into a no-operation
  always_comb begin
    flush_d = 1'b0;
    if (take && skip_hit) begin
      flush_d = 1'b1;                                        // RULE2
    end
  end

  // Skip register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_next <= 1'b0;
    end else begin
      flush_next <= flush_d;
    end
  end

  // Call: push the return address and load the target in the same strobe
  always_comb begin
    push_d  = 1'b0;
    pcl_d   = 1'b0;
    sdata_d = stack_data;
    ptgt_d  = pc_target;
    if (take && op == BTC_CALL) begin
      push_d  = 1'b1;                                        // RULE4
      sdata_d = pc_now + PC_STEP;                            // RULE4
      pcl_d   = 1'b1;                                        // RULE5
      ptgt_d  = instr[11:0];                                 // RULE5
    end
  end

  // Call registers; the return address wraps at the top of the 12-bit space
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_push <= 1'b0;
      stack_data <= PC_RESET;
      pc_load    <= 1'b0;
      pc_target  <= PC_RESET;
    end else begin
      stack_push <= push_d;
      stack_data <= sdata_d;
      pc_load    <= pcl_d;
      pc_target  <= ptgt_d;
    end
  end

  // Register clear; rd_addr only trails instr, bit tests use rd_data in the same cycle
  always_comb begin
    rw_d  = 1'b0;
    rwa_d = reg_wr_addr;
    rwd_d = reg_wr_data;
    rda_d = {1'b0, instr[REG6_W-1:0]};                       // RULE3
    if (take && op == BTC_ZERO_DR) begin
      rw_d  = 1'b1;                                          // RULE7
      rwa_d = instr[REG7_W-1:0];                             // RULE7
      rwd_d = ZERO_BYTE;                                     // RULE7
    end
  end

  // Register clear registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr      <= 1'b0;
      reg_wr_addr <= 7'h00;
      reg_wr_data <= ZERO_BYTE;
      rd_addr     <= 7'h00;
    end else begin
      reg_wr      <= rw_d;
      reg_wr_addr <= rwa_d;
      reg_wr_data <= rwd_d;
      rd_addr     <= rda_d;
    end
  end

  // Accumulator clear; the zero flag is raised by either clear
  always_comb begin
    aw_d  = 1'b0;
    awd_d = acc_wr_data;
    zs_d  = rw_d;                                            // RULE7
    if (take && op == BTC_ZERO_ACC) begin
      aw_d  = 1'b1;                                          // RULE8
      awd_d = ZERO_BYTE;                                     // RULE8
      zs_d  = 1'b1;                                          // RULE8
    end
  end

  // Accumulator and zero flag registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_wr        <= 1'b0;
      acc_wr_data   <= ZERO_BYTE;
      zero_flag_set <= 1'b0;
    end else begin
      acc_wr        <= aw_d;
      acc_wr_data   <= awd_d;
      zero_flag_set <= zs_d;
    end
  end

  // Watchdog kick; the flag values are fixed and only the write strobes carry timing,
  // so the core must qualify expiry_flag and sleep_flag with their strobes
  always_comb begin
    wd_d  = 1'b0;
    exp_d = EXPIRY_ON_KICK;
    slp_d = SLEEP_ON_KICK;
    if (take && op == BTC_KICK_WD) begin
      wd_d = 1'b1;                                           // RULE9
    end
  end

  // Watchdog registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_clear       <= 1'b0;
      expiry_flag_wr <= 1'b0;
      expiry_flag    <= 1'b0;
      sleep_flag_wr  <= 1'b0;
      sleep_flag     <= 1'b0;
    end else begin
      wd_clear       <= wd_d;                                // RULE9
      expiry_flag_wr <= wd_d;                                // RULE9
      expiry_flag    <= exp_d;
      sleep_flag_wr  <= wd_d;                                // RULE9
      sleep_flag     <= slp_d;
    end
  end
endmodule // btc_decode

// file: rtl/btc_pkg.sv
// Package: encodings, field positions and reset values for the bit-test/call/clear decoder
// Operation
// RULE1: test_bit_skip_when_low runs next instruction if bit set, else a two-cycle NOP.
// RULE2: test_bit_skip_when_high runs next instruction if bit clear, else a two-cycle NOP.
// RULE3: Bit tests use bit index 0..7, register 00h..3Fh, touch no status flag.
// RULE4: Call first pushes program_counter plus one onto the return stack.
// RULE5: Call then loads its 12-bit target into program_counter bits 11..0.
// RULE6: Call always takes two cycles and changes no status flag.
// RULE7: zero_data_register writes 00h to register 00h..7Fh and sets zero flag.
// RULE8: zero_accumulator loads 00h into the accumulator and sets zero flag.
// RULE9: kick_watchdog clears the watchdog counter and sets expiry and sleep flags.
// RULE10: Call decodes as top two bits 10 with twelve target bits below.
package btc_pkg;
  localparam int          IW          = 14;
  localparam logic [13:0] OP_ZERO_ACC = 14'h0040;
  localparam logic [13:0] OP_KICK_WD  = 14'h0004;
  localparam logic [4:0]  TOP_SKIP_LO = 5'h0a;   // 01 010
  localparam logic [4:0]  TOP_SKIP_HI = 5'h0b;   // 01 011
  localparam logic [6:0]  TOP_ZERO_DR = 7'h03;   // 00 0001 1
  localparam logic [1:0]  TOP_CALL    = 2'h2;    // 10
  localparam int          BIT_LSB     = 6;
  localparam int          REG6_W      = 6;
  localparam int          REG7_W      = 7;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam logic [11:0] PC_RESET    = 12'h000;
  localparam logic [11:0] PC_STEP     = 12'h001;
  localparam logic        EXPIRY_ON_KICK = 1'b1;
  localparam logic        SLEEP_ON_KICK  = 1'b1;

  typedef enum logic [2:0] {
    BTC_OTHER, BTC_SKIP_LO, BTC_SKIP_HI, BTC_CALL, BTC_ZERO_DR, BTC_ZERO_ACC, BTC_KICK_WD
  } btc_op_t;
endpackage

// file: verification/btc_decode_monitor.sv
// Port-level checker for the bit-test/call/clear decoder
`timescale 1ns/1ps
module btc_decode_monitor import btc_pkg::*; (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [13:0] instr,
  input wire logic [11:0] pc_now,
  input wire logic [7:0]  rd_data,
  input wire logic        busy,
  input wire logic        flush_next,
  input wire logic        stack_push,
  input wire logic [11:0] stack_data,
  input wire logic        pc_load,
  input wire logic [11:0] pc_target,
  input wire logic        reg_wr,
  input wire logic        acc_wr,
  input wire logic        zero_flag_set,
  input wire logic [6:0]  reg_wr_addr,
  input wire logic        wd_clear,
  input wire logic        expiry_flag_wr,
  input wire logic        expiry_flag,
  input wire logic        sleep_flag_wr,
  input wire logic        sleep_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // An offer in the swallow cycle is not taken, so every antecedent needs busy low
  wire tk = instr_valid && !busy;
  wire sk = tk && instr[13:10] == TOP_SKIP_LO[4:1];
  wire cl = tk && instr[13:12] == TOP_CALL;
  a_skip_low_bit: assert property (sk && !instr[9] |=> flush_next == $past(!rd_data[instr[8:6]]))
    else $error("skip when low gave wrong outcome");
  a_skip_high_bit: assert property (sk && instr[9] |=> flush_next == $past(rd_data[instr[8:6]]))
    else $error("skip when high gave wrong outcome");
  a_skip_no_flags: assert property (sk |=> !zero_flag_set && !wd_clear && !stack_push)
    else $error("bit test touched a flag");
  a_call_push_ret: assert property (cl |=> stack_push && stack_data == $past(pc_now) + 12'h001)
    else $error("call pushed wrong return address");
  a_call_load_pc: assert property (cl |=> pc_load && pc_target == $past(instr[11:0]))
    else $error("call loaded wrong target");
  a_call_two_cycles: assert property (cl |=> busy && !zero_flag_set ##1 !busy && !pc_load)
    else $error("call did not take exactly two cycles");
  a_zero_reg_flag: assert property (tk && instr[13:7] == TOP_ZERO_DR |=> reg_wr && zero_flag_set)
    else $error("register clear missing");
  a_zero_acc_flag: assert property (tk && instr == OP_ZERO_ACC |=> acc_wr && zero_flag_set)
    else $error("accumulator clear missing");
  a_zero_reg_addr: assert property (tk && instr[13:7] == TOP_ZERO_DR |=> reg_wr_addr == $past(instr[6:0]))
    else $error("register clear used wrong address");
  a_kick_wd_clear: assert property (tk && instr == OP_KICK_WD |=> wd_clear && expiry_flag_wr && sleep_flag_wr && !acc_wr)
    else $error("watchdog clear missing");
  a_kick_flag_val: assert property (tk && instr == OP_KICK_WD |=> expiry_flag && sleep_flag)
    else $error("watchdog kick wrote wrong flag values");
  c_skip_taken: cover property (sk ##1 flush_next);
  c_call_seen: cover property (cl ##1 busy);
  c_kick_seen: cover property (tk && instr == OP_KICK_WD);
endmodule // btc_decode_monitor

bind btc_decode btc_decode_monitor u_mon (
  .sys_clk        (sys_clk),
  .rst_n          (rst_n),
  .instr_valid    (instr_valid),
  .instr          (instr),
  .pc_now         (pc_now),
  .rd_data        (rd_data),
  .busy           (busy),
  .flush_next     (flush_next),
  .stack_push     (stack_push),
  .stack_data     (stack_data),
  .pc_load        (pc_load),
  .pc_target      (pc_target),
  .reg_wr         (reg_wr),
  .acc_wr         (acc_wr),
  .zero_flag_set  (zero_flag_set),
  .reg_wr_addr    (reg_wr_addr),
  .wd_clear       (wd_clear),
  .expiry_flag_wr (expiry_flag_wr),
  .expiry_flag    (expiry_flag),
  .sleep_flag_wr  (sleep_flag_wr),
  .sleep_flag     (sleep_flag)
);

// file: verification/btc_decode_tb.sv
// Self-checking bench for the bit-test/call/clear decoder
`timescale 1ns/1ps
`define CK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, a, e); end end
module btc_decode_tb;
  import btc_pkg::*;
  logic        sys_clk, rst_n, instr_valid, busy, flush_next, stack_push, pc_load, reg_wr;
  logic        acc_wr, zero_flag_set, wd_clear, expiry_flag_wr, expiry_flag;
  logic        sleep_flag_wr, sleep_flag;
  logic [13:0] instr;
  logic [11:0] pc_now, stack_data, pc_target;
  logic [7:0]  rd_data, reg_wr_data, acc_wr_data;
  logic [6:0]  rd_addr, reg_wr_addr;
  logic [7:0]  mem [64];
  logic [13:0] q[$];
  int          num_errors, check_count, seed;
  btc_decode dut (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .instr_valid    (instr_valid),
    .instr          (instr),
    .pc_now         (pc_now),
    .rd_data        (rd_data),
    .rd_addr        (rd_addr),
    .busy           (busy),
    .flush_next     (flush_next),
    .stack_push     (stack_push),
    .stack_data     (stack_data),
    .pc_load        (pc_load),
    .pc_target      (pc_target),
    .reg_wr         (reg_wr),
    .reg_wr_addr    (reg_wr_addr),
    .reg_wr_data    (reg_wr_data),
    .acc_wr         (acc_wr),
    .acc_wr_data    (acc_wr_data),
    .zero_flag_set  (zero_flag_set),
    .wd_clear       (wd_clear),
    .expiry_flag_wr (expiry_flag_wr),
    .expiry_flag    (expiry_flag),
    .sleep_flag_wr  (sleep_flag_wr),
    .sleep_flag     (sleep_flag)
  );
  // Register file model answers bit tests in the same cycle
  assign rd_data = mem[instr[5:0]];
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic results;
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One instruction against the model; the swallow cycle offers a clear that must be dropped
  task automatic run(input logic [13:0] i, input logic [11:0] p);
    logic sk, cl, zr, za, kw;
    sk = i[13:10] == 4'h5 && mem[i[5:0]][i[8:6]] == i[9];
    cl = i[13:12] == TOP_CALL;
    zr = i[13:7] == TOP_ZERO_DR;
    za = i == OP_ZERO_ACC;
    kw = i == OP_KICK_WD;
    instr = i;
    pc_now = p;
    instr_valid = 1'b1;
    @(negedge sys_clk);
    `CK(flush_next, sk)
    `CK(rd_addr, {1'b0, i[5:0]})
    `CK({busy, stack_push, pc_load}, {sk | cl, cl, cl})
    if (cl) `CK({stack_data, pc_target}, {p + 12'h001, i[11:0]})
    `CK({reg_wr, acc_wr, zero_flag_set}, {zr, za, zr | za})
    if (zr) `CK({reg_wr_addr, reg_wr_data}, {i[6:0], ZERO_BYTE})
    if (za) `CK(acc_wr_data, ZERO_BYTE)
    `CK({wd_clear, expiry_flag_wr, sleep_flag_wr}, {3{kw}})
    `CK({expiry_flag, sleep_flag}, 2'b11)
    if (sk | cl) begin
      instr = OP_ZERO_ACC;
      @(negedge sys_clk);
      `CK({busy, acc_wr, stack_push}, 3'b000)
    end
  endtask
  initial begin
    seed = 24431;
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 14'h0000;
    pc_now = 12'h000;
    foreach (mem[k]) mem[k] = 8'($random(seed));
    mem[0] = 8'h5a;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    // Every bit index under both polarities, back to back
    for (int b = 0; b < 16; b++) run({4'h5, b[3:0], 6'h00}, 12'h000);
    q = '{14'h2fff, 14'h2000, 14'h01ff, 14'h0180, OP_ZERO_ACC, OP_KICK_WD, 14'h1000, 14'h0000};
    foreach (q[k]) run(q[k], 12'hfff);
    $display("Directed test done");
    // Reset in the swallow cycle of a call must drop it and free the next slot
    instr = 14'h2abc;
    @(negedge sys_clk);
    `CK(busy, 1'b1)
    rst_n = 1'b0;
    #1;
    `CK({busy, stack_push, pc_load, expiry_flag, sleep_flag}, 5'h00)
    @(negedge sys_clk);
    rst_n = 1'b1;
    run(OP_ZERO_ACC, 12'h000);
    $display("Reset test done");
    repeat (300) run(14'($random(seed)), 12'($random(seed)));
    $display("Random test done");
    results();
  end
  // Watchdog sized well past the few thousand ns the tests need
  initial begin
    #20000;
    num_errors++;
    results();
  end
endmodule // btc_decode_tb
